// ### verilog/txhcp_defines.vh
// Constants for the transmit HDLC channel provisioning block
// Functional notes
// - Data words are written whole; all byte enables low means no access.
// - FIFO length field holds channel FIFO block count minus one, from start block.
// - FCS diagnostic bit set inverts every bit of the inserted FCS except one forced by LSB stuff.
// - Inversion bit set inverts the whole outgoing stream of that channel.
// - Starve inhibit bit set blocks expedited DMA requests for that channel.
// - LSB stuff forces the last sent bit of each data octet to the forced value before stream inversion.
// - Readable fields return last written value until an indirect read completes.
// - Indirect read completion loads word three fields from the provision RAM.
// - Free space at or above transfer size plus one requests transfer size plus one blocks.
// - Free space, FIFO length and transfer size count sixteen-byte blocks.
// - Burst enable with zero transfer size requests free blocks up to burst maximum.
// - Flag control code n gives 2**n flags, idle bytes two fewer, minimum zero.
// - Each idle fill byte is eight consecutive ones, or eight zeros with stream inversion.
// - Select write with read bit low commits words; high fetches channel values.
// - Busy rises on trigger, stays high until the indirect access completes.
`ifndef TXHCP_DEFINES_VH
`define TXHCP_DEFINES_VH

// Register offsets
`define TXHCP_OFF_SELECT 12'h380
`define TXHCP_OFF_WORD1 12'h384
`define TXHCP_OFF_WORD2 12'h388
`define TXHCP_OFF_WORD3 12'h38C

// Select register fields
`define TXHCP_SEL_BUSY 15
`define TXHCP_SEL_RNW 14
`define TXHCP_SEL_WMASK 16'h43FF

// Readable and writable masks of the data words
`define TXHCP_W1_RMASK 16'hF000
`define TXHCP_W2_RMASK 16'hF000
`define TXHCP_W3_RMASK 16'hCFEF
`define TXHCP_W1_WMASK 16'hFFFF
`define TXHCP_W2_WMASK 16'hFFFF
`define TXHCP_W3_WMASK 16'hCFEF

// Word fields
`define TXHCP_W1_PROV 15
`define TXHCP_W2_LSB_STUFF 15
`define TXHCP_W2_STARVE_INH 14
`define TXHCP_W2_STREAM_INV 13
`define TXHCP_W2_FCS_INV 12
`define TXHCP_W3_IDLE 14

// Packing of one provision RAM entry
`define TXHCP_RAM_W 48
`define TXHCP_RAM_W1_LSB 32
`define TXHCP_RAM_W2_LSB 16

// Fill bytes and buffering
`define TXHCP_FLAG_BYTE 8'h7E
`define TXHCP_IDLE_BYTE 8'hFF
`define TXHCP_FIFO_DEPTH 8
`define TXHCP_FIFO_AW 3
`define TXHCP_ENTRY_W 18
`define TXHCP_RESET_STATE 16'h0000

`endif

// ### verilog/txhcp_storage.v
// Data FIFO and channel provision RAM of the provisioning block
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, valid/ready on both sides
module txhcp_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_reg;
  reg [AW:0] rdPtr_reg;
  wire [AW:0] level = wrPtr_reg - rdPtr_reg;
  wire doPush = inValid & inReady;
  wire doPop = outValid & outReady;

  // Full and empty from the pointer difference
  assign inReady = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg[AW-1:0]];

  // Storage is not reset; only pointers are
  always @(posedge clock) begin
    if (doPush) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always @(posedge clock) begin
    if (rst) begin
      wrPtr_reg <= {(AW+1){1'b0}};
      rdPtr_reg <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// 256-entry provision RAM, one write and three registered read ports
module txhcp_prov_ram (
  input wire clock,
  input wire wrEnable,
  input wire [7:0] wrAddr,
  input wire [47:0] wrData,
  input wire [7:0] hostAddr,
  output reg [47:0] hostData,
  input wire [7:0] pathAddr,
  output reg [47:0] pathData,
  input wire [7:0] reqAddr,
  output reg [47:0] reqData
);
  reg [47:0] mem [0:255];

  // Contents undefined until provisioned
  always @(posedge clock) begin
    if (wrEnable) begin
      mem[wrAddr] <= wrData;
    end
    hostData <= mem[hostAddr];
    pathData <= mem[pathAddr];
    reqData <= mem[reqAddr];
  end
endmodule

// ### verilog/txhcp_channel_provision.v
// Transmit HDLC channel provisioning: registers, octet path and DMA request sizing
`timescale 1ns/1ps
`include "txhcp_defines.vh"

module txhcp_channel_provision (
  input wire clock,
  input wire rst,
  input wire [11:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [3:0] busByteEnables,
  input wire [31:0] regWrData,
  output reg [31:0] regRdData,
  input wire srcValid,
  output wire srcReady,
  input wire [7:0] srcChannel,
  input wire [7:0] srcData,
  input wire srcFcs,
  input wire srcEnd,
  output wire txLinkValid,
  input wire txLinkReady,
  output reg [7:0] txLinkData,
  output reg [7:0] txLinkChannel,
  input wire forcedLastBitValue,
  input wire burstSizeEnable,
  input wire [3:0] burstMax,
  input wire reqValid,
  input wire [7:0] reqChannel,
  input wire [11:0] reqFreeBlocks,
  input wire reqStarving,
  output reg dmaReqValid,
  output reg dmaReqExpedite,
  output reg [7:0] dmaReqChannel,
  output reg [11:0] dmaReqBlocks,
  output reg [10:0] dmaFifoStartBlock,
  output reg [11:0] dmaFifoBlocks
);

  // Indirect access states
  localparam C_IDLE = 4'b0001;
  localparam C_WRITE = 4'b0010;
  localparam C_RD1 = 4'b0100;
  localparam C_RD2 = 4'b1000;

  // Octet path states
  localparam D_LOOK = 4'b0001;
  localparam D_CFG = 4'b0010;
  localparam D_SEND = 4'b0100;
  localparam D_FILL = 4'b1000;

  reg [3:0] ctlState_reg;
  reg [3:0] ctlState_next;
  reg [15:0] select_reg;
  reg [15:0] word1_reg;
  reg [15:0] word1_next;
  reg [15:0] word2_reg;
  reg [15:0] word2_next;
  reg [15:0] word3_reg;
  reg [15:0] word3_next;
  reg [31:0] regRdData_next;

  wire anyByte;
  wire hostWr;
  wire hostRd;
  wire busy;
  wire trigger;
  wire wrWord1;
  wire wrWord2;
  wire wrWord3;
  wire ramWrite;
  wire [47:0] hostRamData;
  wire [47:0] pathRamData;
  wire [47:0] reqRamData;

  ////////////////////////////////////////////////////////////////////////////////
  // Register access decode

  // No byte lanes means no access at all; any lane means a whole word
  assign anyByte = |busByteEnables;
  assign hostWr = regWrite & anyByte;
  assign hostRd = regRead & anyByte;
  assign busy = (ctlState_reg != C_IDLE);
  // A trigger during a running access is dropped, software must poll first
  assign trigger = hostWr & (regAddr == `TXHCP_OFF_SELECT) & ~busy;
  // Data words are frozen while busy so a read cannot race a write
  assign wrWord1 = hostWr & (regAddr == `TXHCP_OFF_WORD1) & ~busy;
  assign wrWord2 = hostWr & (regAddr == `TXHCP_OFF_WORD2) & ~busy;
  assign wrWord3 = hostWr & (regAddr == `TXHCP_OFF_WORD3) & ~busy;
  assign ramWrite = (ctlState_reg == C_WRITE);

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect access sequencer

  // Write takes one cycle, read two for the registered RAM port
  always @* begin
    ctlState_next = ctlState_reg;
    case (ctlState_reg)
      C_IDLE: begin
        if (trigger) begin
          ctlState_next = regWrData[`TXHCP_SEL_RNW] ? C_RD1 : C_WRITE;
        end
      end
      C_WRITE: begin
        ctlState_next = C_IDLE;
      end
      C_RD1: begin
        ctlState_next = C_RD2;
      end
      C_RD2: begin
        ctlState_next = C_IDLE;
      end
      default: begin
        ctlState_next = C_IDLE;
      end
    endcase
  end

  // Data words: host writes, or readable fields refreshed by a read
  always @* begin
    word1_next = word1_reg;
    word2_next = word2_reg;
    word3_next = word3_reg;
    if (wrWord1) begin
      word1_next = regWrData[15:0] & `TXHCP_W1_WMASK;
    end
    if (wrWord2) begin
      word2_next = regWrData[15:0] & `TXHCP_W2_WMASK;
    end
    if (wrWord3) begin
      word3_next = regWrData[15:0] & `TXHCP_W3_WMASK;
    end
    if (ctlState_reg == C_RD2) begin
      // Write-only fields keep what software put there
      word1_next = (word1_reg & ~`TXHCP_W1_RMASK) |
                   (hostRamData[47:32] & `TXHCP_W1_RMASK);
      word2_next = (word2_reg & ~`TXHCP_W2_RMASK) |
                   (hostRamData[31:16] & `TXHCP_W2_RMASK);
      word3_next = hostRamData[15:0] & `TXHCP_W3_RMASK;
    end
  end

  // Read data, one cycle after the strobe
  always @* begin
    regRdData_next = 32'h00000000;
    if (hostRd) begin
      case (regAddr)
        `TXHCP_OFF_SELECT: begin
          regRdData_next = {16'h0000, busy, select_reg[14:0]};
        end
        `TXHCP_OFF_WORD1: begin
          regRdData_next = {16'h0000, word1_reg & `TXHCP_W1_RMASK};
        end
        `TXHCP_OFF_WORD2: begin
          regRdData_next = {16'h0000, word2_reg & `TXHCP_W2_RMASK};
        end
        `TXHCP_OFF_WORD3: begin
          regRdData_next = {16'h0000, word3_reg & `TXHCP_W3_RMASK};
        end
        default: begin
          regRdData_next = 32'h00000000;
        end
      endcase
    end
  end

  // Register state
  always @(posedge clock) begin
    if (rst) begin
      ctlState_reg <= C_IDLE;
      select_reg <= `TXHCP_RESET_STATE;
      word1_reg <= `TXHCP_RESET_STATE;
      word2_reg <= `TXHCP_RESET_STATE;
      word3_reg <= `TXHCP_RESET_STATE;
      regRdData <= 32'h00000000;
    end else begin
      ctlState_reg <= ctlState_next;
      word1_reg <= word1_next;
      word2_reg <= word2_next;
      word3_reg <= word3_next;
      regRdData <= regRdData_next;
      if (trigger) begin
        select_reg <= regWrData[15:0] & `TXHCP_SEL_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Provision RAM and data FIFO

  wire fifoValid;
  wire fifoReady;
  wire [`TXHCP_ENTRY_W-1:0] fifoData;
  reg [3:0] dpState_reg;
  reg [3:0] dpState_next;
  reg [`TXHCP_ENTRY_W-1:0] entry_reg;

  txhcp_prov_ram provRam (
    .clock(clock),
    .wrEnable(ramWrite),
    .wrAddr(select_reg[7:0]),
    .wrData({word1_reg, word2_reg, word3_reg}),
    .hostAddr(select_reg[7:0]),
    .hostData(hostRamData),
    .pathAddr(fifoData[17:10]),
    .pathData(pathRamData),
    .reqAddr(reqChannel),
    .reqData(reqRamData)
  );

  // Entry: channel, octet, FCS marker, end of packet
  txhcp_fifo #(
    .WIDTH(`TXHCP_ENTRY_W),
    .DEPTH(`TXHCP_FIFO_DEPTH),
    .AW(`TXHCP_FIFO_AW)
  ) dataFifo (
    .clock(clock),
    .rst(rst),
    .inValid(srcValid),
    .inReady(srcReady),
    .inData({srcChannel, srcData, srcFcs, srcEnd}),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Octet path: per-channel coding and inter-packet fill

  wire [15:0] pathW1 = pathRamData[47:32];
  wire [15:0] pathW2 = pathRamData[31:16];
  wire [15:0] pathW3 = pathRamData[15:0];
  wire streamInv = pathW2[`TXHCP_W2_STREAM_INV];
  wire [2:0] flagCode = pathW3[7:5];
  wire [7:0] flagCount = 8'h01 << flagCode;
  reg [7:0] fillCount;
  reg [7:0] codedByte;
  reg [7:0] fillByte_reg;
  reg [7:0] fillLeft_reg;

  // Stalling here back-pressures the FIFO and so the source
  assign fifoReady = (dpState_reg == D_LOOK);
  assign txLinkValid = (dpState_reg == D_SEND) | (dpState_reg == D_FILL);

  // Fill length: flags, or idle bytes two fewer and never negative
  always @* begin
    if (pathW3[`TXHCP_W3_IDLE]) begin
      fillCount = (flagCode < 3'h2) ? 8'h00 : flagCount - 8'h02;
    end else begin
      fillCount = flagCount;
    end
  end

  // Octet coding order: FCS inversion, bit forcing, stream inversion
  always @* begin
    codedByte = entry_reg[9:2];
    if (entry_reg[1] & pathW2[`TXHCP_W2_FCS_INV]) begin
      codedByte = ~codedByte;
    end
    if (pathW2[`TXHCP_W2_LSB_STUFF]) begin
      // Bit 0 goes out last on the line
      codedByte[0] = forcedLastBitValue;
    end
    if (streamInv) begin
      codedByte = ~codedByte;
    end
  end

  // Sequencing of one octet and its trailing fill
  always @* begin
    dpState_next = dpState_reg;
    case (dpState_reg)
      D_LOOK: begin
        if (fifoValid) begin
          dpState_next = D_CFG;
        end
      end
      D_CFG: begin
        // Unprovisioned channels swallow their data
        dpState_next = pathW1[`TXHCP_W1_PROV] ? D_SEND : D_LOOK;
      end
      D_SEND: begin
        if (txLinkReady) begin
          if (entry_reg[0] & (fillLeft_reg != 8'h00)) begin
            dpState_next = D_FILL;
          end else begin
            dpState_next = D_LOOK;
          end
        end
      end
      D_FILL: begin
        if (txLinkReady & (fillLeft_reg == 8'h01)) begin
          dpState_next = D_LOOK;
        end
      end
      default: begin
        dpState_next = D_LOOK;
      end
    endcase
  end

  // Octet path registers
  always @(posedge clock) begin
    if (rst) begin
      dpState_reg <= D_LOOK;
      entry_reg <= {`TXHCP_ENTRY_W{1'b0}};
      txLinkData <= 8'h00;
      txLinkChannel <= 8'h00;
      fillByte_reg <= 8'h00;
      fillLeft_reg <= 8'h00;
    end else begin
      dpState_reg <= dpState_next;
      if (dpState_reg == D_LOOK) begin
        entry_reg <= fifoData;
      end
      if (dpState_reg == D_CFG) begin
        txLinkData <= codedByte;
        txLinkChannel <= entry_reg[17:10];
        fillLeft_reg <= fillCount;
        if (pathW3[`TXHCP_W3_IDLE]) begin
          fillByte_reg <= streamInv ? ~`TXHCP_IDLE_BYTE : `TXHCP_IDLE_BYTE;
        end else begin
          fillByte_reg <= streamInv ? ~`TXHCP_FLAG_BYTE : `TXHCP_FLAG_BYTE;
        end
      end
      if ((dpState_reg == D_SEND) & txLinkReady) begin
        txLinkData <= fillByte_reg;
      end
      if ((dpState_reg == D_FILL) & txLinkReady) begin
        fillLeft_reg <= fillLeft_reg - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA request sizing, all quantities in 16-byte blocks

  reg reqPend_reg;
  reg reqStarve_reg;
  reg [7:0] reqChan_reg;
  reg [11:0] reqFree_reg;
  reg [11:0] needBlocks;
  reg grant;

  wire [15:0] reqW1 = reqRamData[47:32];
  wire [15:0] reqW2 = reqRamData[31:16];
  wire [3:0] xferSize = reqRamData[3:0];
  wire variableSize = burstSizeEnable & (xferSize == 4'h0);
  wire [11:0] burstCap = {8'h00, burstMax};

  // Request size and whether free space allows it
  always @* begin
    if (variableSize) begin
      needBlocks = (reqFree_reg < burstCap) ? reqFree_reg : burstCap;
      grant = (needBlocks != 12'h000);
    end else begin
      needBlocks = {8'h00, xferSize} + 12'h001;
      grant = (reqFree_reg >= needBlocks);
    end
  end

  // Query in one cycle, answer after the RAM read
  always @(posedge clock) begin
    if (rst) begin
      reqPend_reg <= 1'b0;
      reqStarve_reg <= 1'b0;
      reqChan_reg <= 8'h00;
      reqFree_reg <= 12'h000;
      dmaReqValid <= 1'b0;
      dmaReqExpedite <= 1'b0;
      dmaReqChannel <= 8'h00;
      dmaReqBlocks <= 12'h000;
      dmaFifoStartBlock <= 11'h000;
      dmaFifoBlocks <= 12'h000;
    end else begin
      reqPend_reg <= reqValid;
      if (reqValid) begin
        reqStarve_reg <= reqStarving;
        reqChan_reg <= reqChannel;
        reqFree_reg <= reqFreeBlocks;
      end
      dmaReqValid <= reqPend_reg & reqW1[`TXHCP_W1_PROV] & grant;
      if (reqPend_reg) begin
        // Inhibited channels only ever make normal requests
        dmaReqExpedite <= reqStarve_reg & ~reqW2[`TXHCP_W2_STARVE_INH];
        dmaReqChannel <= reqChan_reg;
        dmaReqBlocks <= needBlocks;
        dmaFifoStartBlock <= reqW1[10:0];
        dmaFifoBlocks <= {1'b0, reqW2[10:0]} + 12'h001;
      end
    end
  end

endmodule

// ### tb/txhcp_checker.sv
// Port assertions for the channel provisioning block
`timescale 1ns/1ps

module txhcp_checker (
  input wire clock,
  input wire rst,
  input wire [11:0] regAddr,
  input wire regRead,
  input wire [3:0] busByteEnables,
  input wire [31:0] regRdData,
  input wire txLinkValid,
  input wire txLinkReady,
  input wire [7:0] txLinkData,
  input wire reqValid,
  input wire [7:0] reqChannel,
  input wire [11:0] reqFreeBlocks,
  input wire reqStarving,
  input wire dmaReqValid,
  input wire dmaReqExpedite,
  input wire [7:0] dmaReqChannel,
  input wire [11:0] dmaReqBlocks
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Register side
  a_quiet_no_enable: assert property (
    regRead && busByteEnables == 4'h0 |=> regRdData == 32'h0)
    else $error("read without byte enables returned data");
  a_unmapped_zero: assert property (
    regRead && !(regAddr inside {12'h380, 12'h384, 12'h388, 12'h38C}) |=> regRdData == 32'h0)
    else $error("unmapped read returned data");
  a_word3_mask: assert property (
    regRead && regAddr == 12'h38C |=> (regRdData & 32'hFFFF3010) == 32'h0)
    else $error("unused word three bits read nonzero");
  a_data_needs_read: assert property (
    regRdData != 32'h0 |-> $past(regRead))
    else $error("read data without a read");

  ////////////////////////////////////////////////////////////////////////////
  // Request side, answer two edges after the query
  a_expedite_cause: assert property (
    dmaReqValid && dmaReqExpedite |-> $past(reqStarving, 2))
    else $error("expedite without starving query");
  a_req_answer: assert property (
    dmaReqValid |-> $past(reqValid, 2) && dmaReqChannel == $past(reqChannel, 2))
    else $error("request grant without matching query");
  a_req_size: assert property (
    dmaReqValid |-> dmaReqBlocks != 12'h0 && dmaReqBlocks <= 12'h010
      && dmaReqBlocks <= $past(reqFreeBlocks, 2))
    else $error("request size out of range");

  ////////////////////////////////////////////////////////////////////////////
  // Link side holds its octet through a stall
  a_link_hold: assert property (
    txLinkValid && !txLinkReady |=> txLinkValid && $stable(txLinkData))
    else $error("link octet changed while stalled");
endmodule

bind txhcp_channel_provision txhcp_checker chk (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regRead(regRead), .busByteEnables(busByteEnables), .regRdData(regRdData),
  .txLinkValid(txLinkValid), .txLinkReady(txLinkReady), .txLinkData(txLinkData),
  .reqValid(reqValid), .reqChannel(reqChannel), .reqFreeBlocks(reqFreeBlocks),
  .reqStarving(reqStarving), .dmaReqValid(dmaReqValid), .dmaReqExpedite(dmaReqExpedite),
  .dmaReqChannel(dmaReqChannel), .dmaReqBlocks(dmaReqBlocks));

// ### tb/txhcp_link_sink.sv
// Link-side partner that collects coded octets and stalls at random
`timescale 1ns/1ps

module txhcp_link_sink (
  input wire clock,
  input wire rst,
  input wire hold,
  input wire txLinkValid,
  input wire [7:0] txLinkData,
  output logic txLinkReady
);
  logic [7:0] got[$];
  int seed = 32'h5FD47D53;

  // Capture on handshake; ready drops one time in four to stress holding
  always @(posedge clock) begin
    if (!rst && txLinkValid && txLinkReady)
      got.push_back(txLinkData);
    txLinkReady <= !hold && ($random(seed) % 4 != 0);
  end

  initial txLinkReady = 1'b0;
endmodule

// ### tb/tx_hdlc_channel_provision_test.sv
// Self-checking bench for the channel provisioning block
`timescale 1ns/1ps

module tx_hdlc_channel_provision_test;
  logic clock = 0, rst = 1, regWrite = 0, regRead = 0, srcValid = 0, srcFcs = 0, srcEnd = 0;
  logic forcedLastBitValue = 0, burstSizeEnable = 0, reqValid = 0, reqStarving = 0, hold = 0;
  logic [11:0] regAddr = 0, reqFreeBlocks = 0;
  logic [3:0] busByteEnables = 0, burstMax = 0;
  logic [31:0] regWrData = 0, d;
  logic [7:0] srcChannel = 0, srcData = 0, reqChannel = 0, b;
  wire srcReady, txLinkValid, txLinkReady, dmaReqValid, dmaReqExpedite;
  wire [31:0] regRdData;
  wire [7:0] txLinkData, txLinkChannel, dmaReqChannel;
  wire [11:0] dmaReqBlocks, dmaFifoBlocks;
  wire [10:0] dmaFifoStartBlock;
  logic [15:0] w1[6], w2[6], w3[6];
  logic [7:0] expQ[$];
  int seed = 32'h5FD47D53, nErrors = 0, nCompared = 0, ch, n, k, m, fr, blk, x, f, r;
  logic vs, ok;

  txhcp_channel_provision DUT (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .busByteEnables(busByteEnables),
    .regWrData(regWrData), .regRdData(regRdData), .srcValid(srcValid), .srcReady(srcReady),
    .srcChannel(srcChannel), .srcData(srcData), .srcFcs(srcFcs), .srcEnd(srcEnd),
    .txLinkValid(txLinkValid), .txLinkReady(txLinkReady), .txLinkData(txLinkData),
    .txLinkChannel(txLinkChannel), .forcedLastBitValue(forcedLastBitValue),
    .burstSizeEnable(burstSizeEnable), .burstMax(burstMax), .reqValid(reqValid),
    .reqChannel(reqChannel), .reqFreeBlocks(reqFreeBlocks), .reqStarving(reqStarving),
    .dmaReqValid(dmaReqValid), .dmaReqExpedite(dmaReqExpedite),
    .dmaReqChannel(dmaReqChannel), .dmaReqBlocks(dmaReqBlocks),
    .dmaFifoStartBlock(dmaFifoStartBlock), .dmaFifoBlocks(dmaFifoBlocks));

  txhcp_link_sink sink (.clock(clock), .rst(rst), .hold(hold), .txLinkValid(txLinkValid),
    .txLinkData(txLinkData), .txLinkReady(txLinkReady));

  initial begin
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic closeOut;
    $display("compared %0d errors %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A bound ran out: count it and stop
  task automatic stuck;
    check(32'h0, 32'h1);
    closeOut();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, one strobe cycle then a gap
  task automatic regWr(input [11:0] a, input [15:0] v, input [3:0] be);
    @(posedge clock);
    regAddr <= a;
    regWrData <= {16'h0, v};
    busByteEnables <= be;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic regRd(input [11:0] a, output [31:0] v);
    @(posedge clock);
    regAddr <= a;
    busByteEnables <= 4'hF;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask

  // Poll busy low; a new trigger while busy would be lost
  task automatic waitIdle;
    logic [31:0] s;
    for (int i = 0; i < 20; i++) begin
      regRd(12'h380, s);
      if (s[15] === 1'b0) return;
    end
    stuck();
  endtask

  task automatic prov(input int c);
    regWr(12'h384, w1[c], 4'hF);
    regWr(12'h388, w2[c], 4'hF);
    regWr(12'h38C, w3[c], 4'hF);
    regWr(12'h380, 16'(c), 4'hF);
    waitIdle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Octet path helpers
  task automatic push(input int c, input [7:0] v, input fc, input e);
    int t;
    @(posedge clock);
    srcValid <= 1'b1;
    srcChannel <= 8'(c);
    srcData <= v;
    srcFcs <= fc;
    srcEnd <= e;
    @(negedge clock);
    for (t = 0; t < 400 && srcReady !== 1'b1; t++) @(negedge clock);
    if (t == 400) stuck();
    @(posedge clock);
    srcValid <= 1'b0;
  endtask

  function automatic [7:0] code8(input [7:0] v, input fc, input [15:0] c2);
    code8 = (fc && c2[12]) ? ~v : v;
    if (c2[15]) code8[0] = forcedLastBitValue;
    if (c2[13]) code8 = ~code8;
  endfunction

  task automatic drain;
    int t;
    for (t = 0; t < 4000 && sink.got.size() < expQ.size(); t++) @(posedge clock);
    if (t == 4000) stuck();
    repeat (10) @(posedge clock);
    check(32'(sink.got.size()), 32'(expQ.size()));
    while (expQ.size() > 0 && sink.got.size() > 0)
      check(sink.got.pop_front(), expQ.pop_front());
    sink.got.delete();
    expQ.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Reset contents, then one unmapped address
    for (n = 0; n < 5; n++) begin
      regRd(12'h380 + 12'(n * 4), d);
      check(d, 32'h0);
    end
    regWr(12'h38C, 16'hFFFF, 4'h0);
    regRd(12'h38C, d);
    check(d, 32'h0);
    regWr(12'h38C, 16'hFFFF, 4'h1);
    regRd(12'h38C, d);
    check(d, 32'h0000CFEF);
    // Six random channels; zero unprovisioned, one max size, five variable
    for (ch = 0; ch < 6; ch++) begin
      w1[ch] = $random(seed);
      w1[ch][15] = (ch != 0);
      w1[ch][11] = 1'b0;
      w2[ch] = $random(seed);
      w2[ch][11] = 1'b0;
      if (ch == 0) w2[ch][14] = 1'b1;
      w3[ch] = $random(seed) & 16'hCFEF;
      // Start level of 96 blocks or more covers every transfer size
      w3[ch][11:8] = 4'hC;
      if (ch == 1) w3[ch][3:0] = 4'hF;
      if (ch == 5) w3[ch][3:0] = 4'h0;
      prov(ch);
    end
    // Held words survive until a fetch replaces them
    for (ch = 1; ch < 6; ch++) begin
      regWr(12'h38C, 16'h5A5A, 4'hF);
      regRd(12'h38C, d);
      check(d, 32'h00004A4A);
      regWr(12'h380, 16'h4000 | 16'(ch), 4'hF);
      waitIdle();
      regRd(12'h38C, d);
      check(d, {16'h0, w3[ch]});
      regRd(12'h388, d);
      check(d, {16'h0, w2[ch] & 16'hF000});
    end
    // Random DMA queries
    for (n = 0; n < 80; n++) begin
      ch = {$random(seed)} % 6;
      fr = {$random(seed)} % 24;
      @(posedge clock);
      reqValid <= 1'b1;
      reqChannel <= 8'(ch);
      reqFreeBlocks <= 12'(fr);
      reqStarving <= $random(seed);
      burstSizeEnable <= $random(seed);
      burstMax <= $random(seed);
      @(posedge clock);
      reqValid <= 1'b0;
      // Answer pulse stands for the single cycle after this edge
      @(posedge clock);
      #1;
      x = w3[ch][3:0];
      vs = burstSizeEnable && x == 0;
      blk = vs ? (fr < burstMax ? fr : burstMax) : x + 1;
      ok = w1[ch][15] && (vs ? blk != 0 : fr >= x + 1);
      check(dmaReqValid, ok);
      if (ok) begin
        check(dmaReqBlocks, 32'(blk));
        check(dmaReqExpedite, reqStarving && !w2[ch][14]);
        check(dmaFifoBlocks, 32'(w2[ch][10:0]) + 1);
        check(dmaFifoStartBlock, w1[ch][10:0]);
      end
    end
    // Fill the buffer against a stalled link, then drain it
    forcedLastBitValue <= $random(seed);
    hold <= 1'b1;
    @(posedge clock);
    srcValid <= 1'b1;
    srcChannel <= 8'h01;
    srcData <= 8'hA5;
    srcFcs <= 1'b0;
    srcEnd <= 1'b0;
    k = 0;
    repeat (16) begin
      @(negedge clock);
      r = srcReady;
      if (srcReady === 1'b1) k++;
    end
    @(posedge clock);
    srcValid <= 1'b0;
    hold <= 1'b0;
    check(32'(r), 32'h0);
    check(txLinkChannel, 32'h1);
    repeat (k) expQ.push_back(code8(8'hA5, 1'b0, w2[1]));
    drain();
    // Every fill code once, plus a dropped octet on channel zero
    for (n = 0; n < 8; n++) begin
      ch = 1 + n % 4;
      w3[ch][7:5] = 3'(n);
      prov(ch);
      for (k = 0; k < 3; k++) begin
        b = $random(seed);
        f = (k > 0) && ($random(seed) % 2 != 0);
        push(ch, b, f, k == 2);
        expQ.push_back(code8(b, f, w2[ch]));
      end
      m = w3[ch][14] ? (n < 2 ? 0 : (1 << n) - 2) : (1 << n);
      repeat (m) expQ.push_back((w3[ch][14] ? 8'hFF : 8'h7E) ^ {8{w2[ch][13]}});
      push(0, 8'h3C, 1'b0, 1'b1);
      drain();
    end
    closeOut();
  end
endmodule
